//--- tim_map.svh
// Register indices, field positions and timing counts of the tuner I2C master
`ifndef TIM_MAP_SVH
`define TIM_MAP_SVH

// Register indices; byte address is four times the index
`define TIM_IDX_ADDR   8'h55
`define TIM_IDX_DATA0  8'h56
`define TIM_IDX_DATA7  8'h5D
`define TIM_IDX_CTRL   8'h5E
`define TIM_IDX_ISTAT  8'h70
`define TIM_IDX_IMASK  8'h71

// Control register fields
`define TIM_CTRL_LEN_HI  7
`define TIM_CTRL_LEN_LO  5
`define TIM_CTRL_START   2
`define TIM_CTRL_FAST    0

// Interrupt status and mask fields
`define TIM_IRQ_DONE  0
`define TIM_IRQ_NACK  1

// Reset values
`define TIM_RST_BYTE  8'h00
`define TIM_RST_IRQ   2'h0

// Bit index of the acknowledge slot inside a byte
`define TIM_ACK_SLOT  4'h8

// Timing: clock in kHz and the two bus rates in kHz
`define TIM_CLK_KHZ   250000
`define TIM_STD_KHZ   100
`define TIM_FAST_KHZ  400
// Quarter bit time in cycles, rounded up so the rate never exceeds the nominal one
`define TIM_Q_STD   ((`TIM_CLK_KHZ + 4 * `TIM_STD_KHZ - 1) / (4 * `TIM_STD_KHZ))
`define TIM_Q_FAST  ((`TIM_CLK_KHZ + 4 * `TIM_FAST_KHZ - 1) / (4 * `TIM_FAST_KHZ))

`endif

//--- tim_pkg.sv
// Types shared by the tuner I2C master and its payload memory
package tim_pkg;

   // Sequencer states
   typedef enum logic [2:0] {
      TIM_ST_IDLE  = 3'b000,
      TIM_ST_START = 3'b001,
      TIM_ST_BIT   = 3'b010,
      TIM_ST_STOP  = 3'b011,
      TIM_ST_DONE  = 3'b100
   } tim_state_e;

   // Control register contents
   typedef struct packed {
      logic [2:0] len;    // Payload length minus one
      logic       start;  // Transaction request, cleared on completion
      logic       fast;   // 1 = 400 kbps, 0 = 100 kbps
   } tim_ctrl_s;

   // One write into the payload memory
   typedef struct packed {
      logic       en;
      logic [2:0] addr;
      logic [7:0] data;
   } tim_mem_wr_s;

endpackage

//--- tim_payload_mem.sv
// Eight-byte payload memory with one write port and a registered read port
`timescale 1ns/1ps
`include "tim_map.svh"
module tim_payload_mem
   import tim_pkg::*;
#(
   parameter int DEPTH = 8
)
(
   input  wire logic        clk,      // System clock
   input  wire logic        rst_n,    // Asynchronous reset, active low
   input  wire tim_mem_wr_s wr,       // Write request
   input  wire logic [2:0]  rd_addr,  // Read address
   output logic      [7:0]  rd_data   // Read data, one cycle after address
);

   logic [7:0] mem_reg [DEPTH];

   // Storage resets to zero so unused bytes read back as defined values
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < DEPTH; i++)
         begin
            mem_reg[i] <= `TIM_RST_BYTE;
         end
      end
      else if (wr.en)
      begin
         mem_reg[wr.addr] <= wr.data;
      end
   end

   // Registered read keeps the read path out of the bus decode timing
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_data <= `TIM_RST_BYTE;
      end
      else
      begin
         rd_data <= mem_reg[rd_addr];
      end
   end

endmodule

//--- tim_i2c_master.sv
// Register-driven I2C master for short tuner transactions, reached over APB
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`include "tim_map.svh"
module tim_i2c_master
   import tim_pkg::*;
#(
   parameter int ADDR_W = 10
)
(
   input  wire logic              pclk,     // System clock
   input  wire logic              presetn,  // Asynchronous reset, active low
   input  wire logic              psel,     // APB select
   input  wire logic              penable,  // APB access phase
   input  wire logic              pwrite,   // APB direction, 1 = write
   input  wire logic [ADDR_W-1:0] paddr,    // APB byte address
   input  wire logic [31:0]       pwdata,   // APB write data
   output logic      [31:0]       prdata,   // APB read data
   output logic                   pready,   // APB ready
   output logic                   pslverr,  // APB error on unmapped address
   input  wire logic              scl_i,    // Clock line level
   output logic                   scl_o,    // Clock line drive value
   output logic                   scl_oe,   // Clock line pulled low while high
   input  wire logic              sda_i,    // Data line level
   output logic                   sda_o,    // Data line drive value
   output logic                   sda_oe,   // Data line pulled low while high
   output logic                   irq       // Interrupt, level
);

   // Register state
   logic [7:0]  addr_reg;
   tim_ctrl_s   ctrl_reg;
   logic [1:0]  istat_reg;
   logic [1:0]  imask_reg;
   logic [31:0] prdata_reg;
   logic        rd_ph_reg;

   // Line synchronisers
   logic        scl_m_reg;
   logic        scl_s_reg;
   logic        sda_m_reg;
   logic        sda_s_reg;

   // Sequencer state
   tim_state_e  st_reg;
   tim_state_e  st_next;
   logic [1:0]  ph_reg;
   logic [1:0]  ph_next;
   logic [3:0]  bit_reg;
   logic [3:0]  bit_next;
   logic [3:0]  byte_reg;
   logic [3:0]  byte_next;
   logic [7:0]  sh_reg;
   logic [7:0]  sh_next;
   logic        abort_reg;
   logic        abort_next;
   logic        scl_oe_reg;
   logic        scl_oe_next;
   logic        sda_oe_reg;
   logic        sda_oe_next;
   logic [9:0]  qcnt_reg;
   logic        done_ev;
   logic        nack_ev;
   tim_mem_wr_s seq_wr;

   // Payload memory ports
   tim_mem_wr_s mem_wr;
   logic [2:0]  mem_rd_addr;
   logic [7:0]  mem_rd_data;

   // Returns true when the index falls inside the payload window
   function automatic logic is_payload(input logic [7:0] idx);
      is_payload = (idx >= `TIM_IDX_DATA0) && (idx <= `TIM_IDX_DATA7);
   endfunction

   // Maps a register index onto a payload memory slot
   function automatic logic [2:0] payload_slot(input logic [7:0] idx);
      logic [7:0] diff;
      diff = idx - `TIM_IDX_DATA0;
      payload_slot = diff[2:0];
   endfunction

   // Bus decode
   wire [7:0] apb_idx  = paddr[9:2];
   wire       hit_addr = apb_idx == `TIM_IDX_ADDR;
   wire       hit_data = is_payload(apb_idx);
   wire       hit_ctrl = apb_idx == `TIM_IDX_CTRL;
   wire       hit_ist  = apb_idx == `TIM_IDX_ISTAT;
   wire       hit_imk  = apb_idx == `TIM_IDX_IMASK;
   wire       hit_any  = hit_addr | hit_data | hit_ctrl | hit_ist | hit_imk;
   wire       busy     = st_reg != TIM_ST_IDLE;
   wire       wr_acc   = psel & penable & pwrite;
   wire       rd_first = psel & penable & ~pwrite & ~rd_ph_reg;

   // Writes finish in one access cycle; reads take a second for the registered memory
   assign pready  = pwrite | rd_ph_reg;
   assign pslverr = psel & penable & pready & ~hit_any;
   assign prdata  = prdata_reg;

   // Address, payload and control writes are held off while a transaction runs; status and mask writes are not
   wire wr_addr = wr_acc & hit_addr & ~busy;
   wire wr_data = wr_acc & hit_data & ~busy;
   wire wr_ctrl = wr_acc & hit_ctrl & ~busy;
   wire wr_ist  = wr_acc & hit_ist;
   wire wr_imk  = wr_acc & hit_imk;

   // Read data selection
   wire [7:0] ctrl_rd = {ctrl_reg.len, 2'h0, ctrl_reg.start, 1'h0, ctrl_reg.fast};
   wire [7:0] rd_byte = hit_addr ? addr_reg :
                        hit_data ? mem_rd_data :
                        hit_ctrl ? ctrl_rd :
                        hit_ist  ? {6'h00, istat_reg} :
                        hit_imk  ? {6'h00, imask_reg} : `TIM_RST_BYTE;

   // Memory ports: sequencer owns them while busy, the bus otherwise
   assign mem_wr      = busy ? seq_wr : tim_mem_wr_s'{en: wr_data, addr: payload_slot(apb_idx), data: pwdata[7:0]};
   assign mem_rd_addr = busy ? byte_reg[2:0] : payload_slot(apb_idx);

   tim_payload_mem #(
      .DEPTH (8)
   ) u_mem (
      .clk     (pclk),
      .rst_n   (presetn),
      .wr      (mem_wr),
      .rd_addr (mem_rd_addr),
      .rd_data (mem_rd_data)
   );

   // Bus-side registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         addr_reg   <= `TIM_RST_BYTE;
         imask_reg  <= `TIM_RST_IRQ;
         prdata_reg <= 32'h0000_0000;
         rd_ph_reg  <= 1'b0;
      end
      else
      begin
         rd_ph_reg <= rd_first;
         if (wr_addr)
            addr_reg <= pwdata[7:0];
         if (wr_imk)
            imask_reg <= pwdata[1:0];
         if (rd_first)
            prdata_reg <= {24'h00_0000, rd_byte};
      end
   end

   // Control register; the completion clear only applies when no write lands
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_reg <= '0;
      end
      else if (wr_ctrl)
      begin
         ctrl_reg.len   <= pwdata[`TIM_CTRL_LEN_HI:`TIM_CTRL_LEN_LO];
         ctrl_reg.start <= pwdata[`TIM_CTRL_START];
         ctrl_reg.fast  <= pwdata[`TIM_CTRL_FAST];
      end
      else if (done_ev)
      begin
         ctrl_reg.start <= 1'b0;
      end
   end

   // Sticky events: a new event wins over a write-one clear in the same cycle
   wire [1:0] ev_vec   = {nack_ev, done_ev};
   wire [1:0] ist_clr  = wr_ist ? pwdata[1:0] : 2'b00;
   wire [1:0] ist_next = (istat_reg & ~ist_clr) | ev_vec;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         istat_reg <= `TIM_RST_IRQ;
      else
         istat_reg <= ist_next;
   end

   assign irq = |(istat_reg & imask_reg);

   // Two-stage synchronisers on both bus lines
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         scl_m_reg <= 1'b1;
         scl_s_reg <= 1'b1;
         sda_m_reg <= 1'b1;
         sda_s_reg <= 1'b1;
      end
      else
      begin
         scl_m_reg <= scl_i;
         scl_s_reg <= scl_m_reg;
         sda_m_reg <= sda_i;
         sda_s_reg <= sda_m_reg;
      end
   end

   // Quarter-bit timebase for the selected rate
   wire [9:0] q_lim = ctrl_reg.fast ? 10'(`TIM_Q_FAST - 1) : 10'(`TIM_Q_STD - 1);
   wire       tick  = busy & (qcnt_reg == q_lim);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         qcnt_reg <= 10'h000;
      else if (!busy || tick)
         qcnt_reg <= 10'h000;
      else
         qcnt_reg <= qcnt_reg + 10'h001;
   end

   // Byte role decode
   wire       rd_dir    = addr_reg[0];
   wire [3:0] last_byte = 4'(ctrl_reg.len) + 4'h1;
   wire       on_ack    = bit_reg == `TIM_ACK_SLOT;
   wire       is_addr   = byte_reg == 4'h0;
   wire       slave_tx  = rd_dir & ~is_addr;
   wire       at_last   = byte_reg == last_byte;
   // A slave holding the clock low stretches the high phase
   wire       stall     = (st_reg == TIM_ST_BIT) & (ph_reg == 2'h2) & ~scl_s_reg;
   wire       adv       = tick & ~stall;
   wire       go        = (st_reg == TIM_ST_IDLE) & ctrl_reg.start;

   // Sequencer next state
   always_comb
   begin
      st_next     = st_reg;
      ph_next     = ph_reg;
      bit_next    = bit_reg;
      byte_next   = byte_reg;
      sh_next     = sh_reg;
      abort_next  = abort_reg;
      scl_oe_next = scl_oe_reg;
      sda_oe_next = sda_oe_reg;
      done_ev     = 1'b0;
      nack_ev     = 1'b0;
      seq_wr      = '0;
      if (go)
      begin
         st_next    = TIM_ST_START;
         ph_next    = 2'h0;
         bit_next   = 4'h0;
         byte_next  = 4'h0;
         abort_next = 1'b0;
         sh_next    = addr_reg;
      end
      else if (st_reg == TIM_ST_DONE)
      begin
         done_ev = 1'b1;
         st_next = TIM_ST_IDLE;
      end
      else if (adv)
      begin
         ph_next = ph_reg + 2'h1;
         case (st_reg)
            TIM_ST_START:
            begin
               if (ph_reg == 2'h1)
                  sda_oe_next = 1'b1;
               if (ph_reg == 2'h3)
               begin
                  scl_oe_next = 1'b1;
                  st_next     = TIM_ST_BIT;
               end
            end
            TIM_ST_BIT:
            begin
               case (ph_reg)
                  2'h0:
                  begin
                     // Master ack low on read bytes except the last, which it leaves high
                     if (on_ack)
                        sda_oe_next = slave_tx & ~at_last;
                     else
                        sda_oe_next = ~slave_tx & ~sh_reg[7];
                     if (on_ack && slave_tx)
                        seq_wr = '{en: 1'b1, addr: 3'(byte_reg - 4'h1), data: sh_reg};
                  end
                  2'h1:
                     scl_oe_next = 1'b0;
                  2'h2:
                  begin
                     if (!on_ack)
                        sh_next = {sh_reg[6:0], sda_s_reg};
                     else if (!slave_tx && sda_s_reg)
                     begin
                        nack_ev    = 1'b1;
                        abort_next = 1'b1;
                     end
                  end
                  default:
                  begin
                     scl_oe_next = 1'b1;
                     bit_next    = bit_reg + 4'h1;
                     if (on_ack)
                     begin
                        bit_next  = 4'h0;
                        byte_next = byte_reg + 4'h1;
                        sh_next   = mem_rd_data;
                        if (abort_reg || at_last)
                           st_next = TIM_ST_STOP;
                     end
                  end
               endcase
            end
            TIM_ST_STOP:
            begin
               case (ph_reg)
                  2'h0:    sda_oe_next = 1'b1;
                  2'h1:    scl_oe_next = 1'b0;
                  2'h2:    sda_oe_next = 1'b0;
                  default: st_next     = TIM_ST_DONE;
               endcase
            end
            default:
               st_next = TIM_ST_IDLE;
         endcase
      end
   end

   // Sequencer registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_reg     <= TIM_ST_IDLE;
         ph_reg     <= 2'h0;
         bit_reg    <= 4'h0;
         byte_reg   <= 4'h0;
         sh_reg     <= `TIM_RST_BYTE;
         abort_reg  <= 1'b0;
         scl_oe_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
      end
      else
      begin
         st_reg     <= st_next;
         ph_reg     <= ph_next;
         bit_reg    <= bit_next;
         byte_reg   <= byte_next;
         sh_reg     <= sh_next;
         abort_reg  <= abort_next;
         scl_oe_reg <= scl_oe_next;
         sda_oe_reg <= sda_oe_next;
      end
   end

   // Open-drain lines only ever pull low
   assign scl_o  = 1'b0;
   assign sda_o  = 1'b0;
   assign scl_oe = scl_oe_reg;
   assign sda_oe = sda_oe_reg;

endmodule

//--- tim_i2c_master_sva.sv
// Port assertions of the tuner I2C master
`timescale 1ns/1ps
module tim_i2c_master_sva #(parameter int ADDR_W = 10)
(
   input wire logic              pclk,    // Clock
   input wire logic              presetn, // Reset
   input wire logic              psel,    // APB
   input wire logic              penable, // APB
   input wire logic              pwrite,  // APB
   input wire logic [ADDR_W-1:0] paddr,   // APB
   input wire logic [31:0]       prdata,  // APB
   input wire logic              pready,  // APB
   input wire logic              pslverr, // APB
   input wire logic              scl_oe,  // Clock pull
   input wire logic              sda_oe   // Data pull
);
   localparam int LO_MIN = 150;
   logic [15:0] lo_cnt;
   wire  [7:0]  idx = 8'(paddr[ADDR_W-1:2]);
   wire         xfer = psel && penable && pready;
   // Decode; a miss must end in an error
   wire         hit = idx inside {[8'h55:8'h5E], 8'h70, 8'h71};
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Length of the clock low phase, so a too fast bus shows
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         lo_cnt <= 16'h0000;
      else
         lo_cnt <= scl_oe ? lo_cnt + 16'h0001 : 16'h0000;
   wr_no_wait_a:
      assert property (psel && penable && pwrite |-> pready) else $error("write stalled");
   rd_one_wait_a:
      assert property (psel && $rose(penable) && !pwrite |-> !pready ##1 pready) else $error("read wait wrong");
   rd_upper_a:
      assert property (xfer && !pwrite |-> prdata[31:8] == 24'h0) else $error("read upper bits set");
   err_decode_a:
      assert property (pslverr == (xfer && !hit)) else $error("error flag wrong");
   err_rd_zero_a:
      assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("unmapped read not zero");
   scl_low_a:
      assert property ($fell(scl_oe) |-> $past(lo_cnt) >= LO_MIN) else $error("clock low too short");
   start_hold_a:
      assert property ($rose(sda_oe) && !scl_oe |-> !scl_oe [*8]) else $error("start not held");
   stop_idle_a:
      assert property ($fell(sda_oe) && !scl_oe |-> !(scl_oe || sda_oe) [*8]) else $error("stop not idle");
endmodule
bind tim_i2c_master tim_i2c_master_sva #(.ADDR_W(ADDR_W)) chk (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .prdata, .pready, .pslverr, .scl_oe, .sda_oe);

//--- tim_tuner_model.sv
// Behavioural tuner slave on the open-drain link
`timescale 1ns/1ps
module tim_tuner_model
(
   input  wire logic        scl,      // Clock line
   input  wire logic        sda,      // Data line
   input  wire logic [6:0]  dev_addr, // Own address
   input  wire logic [15:0] rd_bytes, // Reply, first in low byte
   input  wire logic        stretch,  // Answer slowly
   output logic             scl_drv,  // Pulls clock low
   output logic             sda_drv,  // Pulls data low
   output logic             note_tgl, // Toggles per unit seen
   output logic      [7:0]  note_val  // Byte or ack bit seen
);
   logic [7:0] b;
   logic       hit;
   logic       rw;
   int         n;
   initial
   begin
      scl_drv = 1'h0;
      sda_drv = 1'h0;
      note_tgl = 1'h0;
   end
   task automatic put(input logic [7:0] v);
      note_val = v;
      note_tgl = ~note_tgl;
   endtask
   // One byte, MSB first; stretching only mid-byte keeps stops clean
   // The hold outlasts the master's first high-phase sample point, so the master must stall
   task automatic get_byte();
      for (int i = 0; i < 8; i++)
      begin
         if (stretch && i == 3)
         begin
            @(negedge scl);
            scl_drv = 1'h1;
            #2200 scl_drv = 1'h0;
         end
         @(posedge scl);
         b = {b[6:0], sda};
      end
      put(b);
   endtask
   task automatic ack_slot(input logic a);
      @(negedge scl);
      sda_drv = a;
      @(negedge scl);
      sda_drv = 1'h0;
   endtask
   // One frame from its start; a stop aborts it anywhere
   always
   begin : frame
      @(negedge sda iff scl === 1'h1);
      n = 0;
      get_byte();
      hit = b[7:1] == dev_addr;
      rw = b[0];
      ack_slot(hit);
      forever
         if (!hit)
            @(negedge scl);
         else if (rw)
         begin
            for (int i = 7; i >= 0; i--)
            begin
               sda_drv = !rd_bytes[8*n+i];
               @(negedge scl);
            end
            sda_drv = 1'h0;
            @(posedge scl);
            put({7'h0, sda});
            hit = !sda;
            n++;
            @(negedge scl);
         end
         else
         begin
            get_byte();
            ack_slot(1'h1);
         end
   end
   always @(posedge sda)
      if (scl === 1'h1)
      begin
         disable frame;
         sda_drv = 1'h0;
         scl_drv = 1'h0;
      end
endmodule

//--- tuner_i2c_master_regs_bench.sv
// Self-checking bench of the tuner I2C master with a tuner model
`timescale 1ns/1ps
`include "tim_map.svh"
module tuner_i2c_master_regs_bench;
   logic        pclk = 1'h0;
   logic        presetn = 1'h0;
   logic        psel = 1'h0;
   logic        penable = 1'h0;
   logic        pwrite = 1'h0;
   logic        stretch = 1'h0;
   logic [9:0]  paddr = 10'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, scl_oe, sda_oe, scl_drv, sda_drv, irq, tgl;
   logic [7:0]  nv;
   logic [7:0]  pay [8];
   logic [6:0]  dev;
   logic [15:0] rdb;
   logic [7:0]  ri [7] = '{`TIM_IDX_ADDR, `TIM_IDX_DATA0, `TIM_IDX_DATA7, `TIM_IDX_CTRL, `TIM_IDX_IMASK,
                           `TIM_IDX_ISTAT, 8'h60};
   logic [31:0] q [$];
   int          seed = 57, bad_count = 0, checks = 0, cyc = 0, t0;
   // Open-drain lines with pull-ups
   wire         scl = !(scl_oe | scl_drv);
   wire         sda = !(sda_oe | sda_drv);
   always #2 pclk = ~pclk;
   tim_i2c_master uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .scl_i(scl), .scl_o(), .scl_oe, .sda_i(sda), .sda_o(), .sda_oe, .irq);
   tim_tuner_model tuner (.scl, .sda, .dev_addr(dev), .rd_bytes(rdb), .stretch, .scl_drv, .sda_drv,
      .note_tgl(tgl), .note_val(nv));
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e)
      begin
         bad_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic complete_run();
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // One APB transfer, held until ready is seen high
   task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= {i, 2'h0};
      pwdata <= {24'($random(seed)), d};
      @(posedge pclk);
      penable <= 1'h1;
      // Ready is judged at the rising edge that completes the access; release follows that edge
      do @(posedge pclk); while (pready !== 1'h1);
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] i, input logic [31:0] e);
      q.push_back(e);
      apb(1'h0, i, 8'h00);
   endtask
   task automatic irq_is(input logic e);
      @(negedge pclk);
      check(irq, e);
   endtask
   // Results paired with the oldest note
   task automatic take(input logic [31:0] s);
      check(s, q.size() ? q.pop_front() : 32'hX);
   endtask
   always @(posedge pclk)
      if (psel && penable && pready && !pwrite)
         take(prdata);
   always @(tgl)
      if (presetn)
         take({24'h0, nv});
   // One transaction: notes, set up, start, completion, interrupt
   task automatic run(input logic [7:0] ab, input logic [2:0] n, input logic f, input logic [7:0] st,
                      input int lo, input int hi);
      q.push_back({24'h0, ab});
      if (!st[1])
         for (int k = 0; k <= n; k++)
            q.push_back(ab[0] ? 32'(k == n) : {24'h0, pay[k]});
      apb(1'h1, `TIM_IDX_ADDR, ab);
      for (int k = 0; k <= n; k++)
         apb(1'h1, `TIM_IDX_DATA0 + 8'(k), pay[k]);
      apb(1'h1, `TIM_IDX_CTRL, {n, 4'h2, f});
      t0 = cyc;
      apb(1'h1, `TIM_IDX_ADDR, 8'hFF);
      do @(negedge pclk); while (irq !== 1'h1);
      check((cyc - t0) >= lo && (cyc - t0) <= hi, 1'h1);
      rd(`TIM_IDX_ADDR, {24'h0, ab});
      rd(`TIM_IDX_CTRL, {24'h0, n, 4'h0, f});
      rd(`TIM_IDX_ISTAT, {24'h0, st});
      apb(1'h1, `TIM_IDX_IMASK, 8'h00);
      irq_is(1'h0);
      apb(1'h1, `TIM_IDX_IMASK, 8'h01);
      irq_is(1'h1);
      apb(1'h1, `TIM_IDX_ISTAT, 8'h03);
      irq_is(1'h0);
   endtask
   // Hang guard
   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 90000)
      begin
         bad_count++;
         complete_run();
      end
   end
   // Main sequence
   initial
   begin
      dev = 7'($random(seed));
      rdb = 16'($random(seed));
      foreach (pay[k])
         pay[k] = 8'($random(seed));
      repeat (12) @(posedge pclk);
      presetn <= 1'h1;
      apb(1'h1, 8'h60, 8'hFF);
      foreach (ri[k])
         rd(ri[k], 32'h0);
      apb(1'h1, `TIM_IDX_IMASK, 8'h01);
      stretch = 1'h1;
      run({dev, 1'h0}, 3'h2, 1'h1, 8'h01, 24400, 30000);
      stretch = 1'h0;
      run({dev, 1'h1}, 3'h1, 1'h1, 8'h01, 16956, 22000);
      rd(`TIM_IDX_DATA0, {24'h0, rdb[7:0]});
      rd(8'h57, {24'h0, rdb[15:8]});
      run({~dev, 1'h0}, 3'h0, 1'h0, 8'h03, 22500, 32000);
      // Every note must have met its result; a leftover one is a missing unit on the link
      check(q.size(), 32'h0);
      complete_run();
   end
endmodule
